// ### hdl/awc_window_comparator.sv
// adc window comparator: limit registers, window test, match flag, interrupt
`timescale 1ns/1ns
`include "awc_params.svh"

module awc_window_comparator
  import awc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [`AWC_ADDR_W-1:0] reg_addr,
  input wire logic [`AWC_BYTE_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output awc_byte_t reg_rdata,
  input wire logic conv_done,
  input wire logic [`AWC_RAW_W-1:0] conv_raw,
  output logic window_match_flag,
  output logic irq
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  awc_byte_t gt_limit_low_byte;
  awc_byte_t gt_limit_high_byte;
  awc_byte_t lt_limit_low_byte;
  awc_byte_t lt_limit_high_byte;
  logic left_justify_select;
  logic diff_select;
  awc_evt_t irq_status;
  awc_evt_t irq_mask;

  awc_byte_t next_gt_limit_low_byte;
  awc_byte_t next_gt_limit_high_byte;
  awc_byte_t next_lt_limit_low_byte;
  awc_byte_t next_lt_limit_high_byte;
  logic next_left_justify_select;
  logic next_diff_select;
  logic next_window_match_flag;
  awc_evt_t next_irq_status;
  awc_evt_t next_irq_mask;
  logic next_irq;
  awc_byte_t next_reg_rdata;

  awc_word_t result_word;
  logic result_signed;
  logic result_valid;

  awc_word_t gt_word;
  awc_word_t lt_word;
  awc_cmp_t res_x;
  awc_cmp_t gt_x;
  awc_cmp_t lt_x;
  logic above_gt;
  logic below_lt;
  logic window_hit;
  awc_evt_t evt_set;
  awc_evt_t evt_clr;
  logic ctrl_wr;

  // --------------------------------------------------------------------------
  // result formatting
  // --------------------------------------------------------------------------
  awc_result_format u_format (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .conv_done(conv_done),
    .conv_raw(conv_raw),
    .left_justify_select(left_justify_select),
    .diff_select(diff_select),
    .result_word(result_word),
    .result_signed(result_signed),
    .result_valid(result_valid)
  );

  // --------------------------------------------------------------------------
  // window test
  // --------------------------------------------------------------------------
  assign gt_word = {gt_limit_high_byte, gt_limit_low_byte};
  assign lt_word = {lt_limit_high_byte, lt_limit_low_byte};

  // limits are read live, so a half-written limit pair is seen as is;
  // software should update limits between conversions
  always_comb begin
    if (result_signed) begin
      res_x = {result_word[`AWC_WORD_W-1], result_word};
      gt_x = {gt_word[`AWC_WORD_W-1], gt_word};
      lt_x = {lt_word[`AWC_WORD_W-1], lt_word};
    end else begin
      res_x = {1'b0, result_word};
      gt_x = {1'b0, gt_word};
      lt_x = {1'b0, lt_word};
    end
  end

  assign above_gt = res_x > gt_x;
  assign below_lt = res_x < lt_x;

  always_comb begin
    // inside or outside follows only from limit order
    if (lt_x > gt_x) begin
      window_hit = below_lt && above_gt;
    end else begin
      window_hit = below_lt || above_gt;
    end
  end

  // --------------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------------
  assign ctrl_wr = reg_wr && (reg_addr == `AWC_OFS_CTRL);

  always_comb begin
    next_gt_limit_low_byte = gt_limit_low_byte;
    next_gt_limit_high_byte = gt_limit_high_byte;
    next_lt_limit_low_byte = lt_limit_low_byte;
    next_lt_limit_high_byte = lt_limit_high_byte;
    next_left_justify_select = left_justify_select;
    next_diff_select = diff_select;
    next_irq_mask = irq_mask;
    if (reg_wr) begin
      unique case (reg_addr)
        `AWC_OFS_GT_LOW: begin
          next_gt_limit_low_byte = reg_wdata;
        end
        `AWC_OFS_GT_HIGH: begin
          next_gt_limit_high_byte = reg_wdata;
        end
        `AWC_OFS_LT_LOW: begin
          next_lt_limit_low_byte = reg_wdata;
        end
        `AWC_OFS_LT_HIGH: begin
          next_lt_limit_high_byte = reg_wdata;
        end
        `AWC_OFS_IRQ_MASK: begin
          next_irq_mask = reg_wdata[`AWC_EVT_N-1:0];
        end
        `AWC_OFS_CTRL: begin
          next_left_justify_select = reg_wdata[`AWC_CTRL_LJST_BIT];
          next_diff_select = reg_wdata[`AWC_CTRL_DIFF_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // match flag
  // --------------------------------------------------------------------------
  always_comb begin
    next_window_match_flag = window_match_flag;
    // writing zero clears, writing one leaves it alone
    if (ctrl_wr && !reg_wdata[`AWC_CTRL_MATCH_BIT]) begin
      next_window_match_flag = 1'b0;
    end
    // a match in the clearing cycle wins, so no event is lost
    if (result_valid && window_hit) begin
      next_window_match_flag = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // interrupt status, write one to clear, set wins
  // --------------------------------------------------------------------------
  assign evt_set[`AWC_EVT_MATCH_BIT] = result_valid && window_hit;
  assign evt_set[`AWC_EVT_DONE_BIT] = result_valid;
  assign evt_clr = (reg_wr && (reg_addr == `AWC_OFS_IRQ_STATUS))
    ? reg_wdata[`AWC_EVT_N-1:0] : `AWC_RST_EVT;

  genvar gi;
  generate
    for (gi = 0; gi < `AWC_EVT_N; gi++) begin : g_evt
      assign next_irq_status[gi] = evt_set[gi] || (irq_status[gi] && !evt_clr[gi]);
    end
  endgenerate

  assign next_irq = |(next_irq_status & next_irq_mask);

  // --------------------------------------------------------------------------
  // register reads: data stand in the cycle after the strobe only
  // --------------------------------------------------------------------------
  always_comb begin
    next_reg_rdata = `AWC_RST_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        `AWC_OFS_RES_LOW: begin
          next_reg_rdata = result_word[`AWC_BYTE_W-1:0];
        end
        `AWC_OFS_RES_HIGH: begin
          next_reg_rdata = result_word[`AWC_WORD_W-1:`AWC_BYTE_W];
        end
        `AWC_OFS_GT_LOW: begin
          next_reg_rdata = gt_limit_low_byte;
        end
        `AWC_OFS_GT_HIGH: begin
          next_reg_rdata = gt_limit_high_byte;
        end
        `AWC_OFS_LT_LOW: begin
          next_reg_rdata = lt_limit_low_byte;
        end
        `AWC_OFS_LT_HIGH: begin
          next_reg_rdata = lt_limit_high_byte;
        end
        `AWC_OFS_IRQ_STATUS: begin
          next_reg_rdata[`AWC_EVT_N-1:0] = irq_status;
        end
        `AWC_OFS_IRQ_MASK: begin
          next_reg_rdata[`AWC_EVT_N-1:0] = irq_mask;
        end
        `AWC_OFS_CTRL: begin
          next_reg_rdata[`AWC_CTRL_LJST_BIT] = left_justify_select;
          next_reg_rdata[`AWC_CTRL_MATCH_BIT] = window_match_flag;
          next_reg_rdata[`AWC_CTRL_DIFF_BIT] = diff_select;
        end
        default: begin
          // unmapped offsets read as zero
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gt_limit_low_byte <= `AWC_RST_GT_LOW;
      gt_limit_high_byte <= `AWC_RST_GT_HIGH;
      lt_limit_low_byte <= `AWC_RST_LT_LOW;
      lt_limit_high_byte <= `AWC_RST_LT_HIGH;
      left_justify_select <= 1'b0;
      diff_select <= 1'b0;
      window_match_flag <= 1'b0;
      irq_status <= `AWC_RST_EVT;
      irq_mask <= `AWC_RST_EVT;
      irq <= 1'b0;
      reg_rdata <= `AWC_RST_BYTE;
    end else begin
      gt_limit_low_byte <= next_gt_limit_low_byte;
      gt_limit_high_byte <= next_gt_limit_high_byte;
      lt_limit_low_byte <= next_lt_limit_low_byte;
      lt_limit_high_byte <= next_lt_limit_high_byte;
      left_justify_select <= next_left_justify_select;
      diff_select <= next_diff_select;
      window_match_flag <= next_window_match_flag;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule : awc_window_comparator

// ### inc/awc_params.svh
// constants and contract of the adc window comparator
//
// Contract
// - at every end of conversion the new result is checked against both limits and the match flag is set when the window condition holds.
// - each limit is one 16-bit word built from a separately writable high byte and low byte.
// - when the less-than limit is above the greater-than limit, a match needs result below less-than and above greater-than.
// - when the less-than limit is not above the greater-than limit, a match needs result below less-than or above greater-than.
// - differential results and limits are compared as signed 16-bit two's complement values.
// - with left justification the justified 16-bit word is compared as is, so limits must use the same format.
// - inside or outside matching follows only from the ordering of the two limits, with no mode bit.
// - the match flag stays set until software writes it to zero and hardware never clears it.
// - the left-justify control picks right justified (sign extended in differential mode, zero extended otherwise) or left justified with zero low bits.
`ifndef AWC_PARAMS_SVH
`define AWC_PARAMS_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define AWC_RAW_W 10
`define AWC_WORD_W 16
`define AWC_BYTE_W 8
`define AWC_ADDR_W 8
`define AWC_PAD_W 6
`define AWC_EVT_N 2

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define AWC_OFS_RES_LOW 8'hbe
`define AWC_OFS_RES_HIGH 8'hbf
`define AWC_OFS_GT_LOW 8'hc4
`define AWC_OFS_GT_HIGH 8'hc5
`define AWC_OFS_LT_LOW 8'hc6
`define AWC_OFS_LT_HIGH 8'hc7
`define AWC_OFS_IRQ_STATUS 8'hd0
`define AWC_OFS_IRQ_MASK 8'hd1
`define AWC_OFS_CTRL 8'he8

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define AWC_CTRL_LJST_BIT 0
`define AWC_CTRL_MATCH_BIT 1
`define AWC_CTRL_DIFF_BIT 2

// ----------------------------------------------------------------------------
// interrupt status and mask fields
// ----------------------------------------------------------------------------
`define AWC_EVT_MATCH_BIT 0
`define AWC_EVT_DONE_BIT 1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define AWC_RST_GT_LOW 8'hff
`define AWC_RST_GT_HIGH 8'hff
`define AWC_RST_LT_LOW 8'h00
`define AWC_RST_LT_HIGH 8'h00
`define AWC_RST_BYTE 8'h00
`define AWC_RST_WORD 16'h0000
`define AWC_RST_EVT 2'h0

`endif

// ### inc/awc_pkg.sv
// types shared by the adc window comparator files
`include "awc_params.svh"

package awc_pkg;

  typedef logic [`AWC_WORD_W-1:0] awc_word_t;
  typedef logic [`AWC_BYTE_W-1:0] awc_byte_t;
  typedef logic [`AWC_EVT_N-1:0] awc_evt_t;
  // one extra bit so signed and unsigned words share one signed compare
  typedef logic signed [`AWC_WORD_W:0] awc_cmp_t;

endpackage : awc_pkg

// ### hdl/awc_result_format.sv
// result formatter: justifies a raw conversion result into a 16-bit word
`timescale 1ns/1ns
`include "awc_params.svh"

module awc_result_format
  import awc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic conv_done,
  input wire logic [`AWC_RAW_W-1:0] conv_raw,
  input wire logic left_justify_select,
  input wire logic diff_select,
  output awc_word_t result_word,
  output logic result_signed,
  output logic result_valid
);

  awc_word_t next_result_word;
  logic next_result_signed;
  logic next_result_valid;

  // --------------------------------------------------------------------------
  // justification
  // --------------------------------------------------------------------------
  always_comb begin
    next_result_word = result_word;
    next_result_signed = result_signed;
    next_result_valid = conv_done;
    if (conv_done) begin
      // mode is latched with the word so a later mode change cannot skew it
      next_result_signed = diff_select;
      if (left_justify_select) begin
        next_result_word = {conv_raw, {`AWC_PAD_W{1'b0}}};
      end else if (diff_select) begin
        next_result_word = {{`AWC_PAD_W{conv_raw[`AWC_RAW_W-1]}}, conv_raw};
      end else begin
        next_result_word = {{`AWC_PAD_W{1'b0}}, conv_raw};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      result_word <= `AWC_RST_WORD;
      result_signed <= 1'b0;
      result_valid <= 1'b0;
    end else begin
      result_word <= next_result_word;
      result_signed <= next_result_signed;
      result_valid <= next_result_valid;
    end
  end

endmodule : awc_result_format

// ### testbench/awc_window_comparator_asserts.sv
// concurrent checks on the window comparator ports
`timescale 1ns/1ns
`include "awc_params.svh"

module awc_window_comparator_asserts
  import awc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [`AWC_ADDR_W-1:0] reg_addr,
  input wire logic [`AWC_BYTE_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire awc_byte_t reg_rdata,
  input wire logic conv_done,
  input wire logic [`AWC_RAW_W-1:0] conv_raw,
  input wire logic window_match_flag,
  input wire logic irq
);
  logic ctrl_wr;
  logic evt_wr;
  logic lim_wr;
  logic mapped;
  assign ctrl_wr = reg_wr && reg_addr == `AWC_OFS_CTRL;
  assign evt_wr = reg_wr && reg_addr inside {`AWC_OFS_IRQ_STATUS, `AWC_OFS_IRQ_MASK};
  assign lim_wr = reg_wr && reg_addr inside {[`AWC_OFS_GT_LOW:`AWC_OFS_LT_HIGH]};
  assign mapped = reg_addr inside {[8'hbe:8'hbf], [8'hc4:8'hc7], [8'hd0:8'hd1], 8'he8};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property ($past(reg_rd && !mapped) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_limit_read_back: assert property (
    lim_wr ##1 (reg_rd && reg_addr == $past(reg_addr)) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("limit byte read back differs from write");
  a_flag_from_conv: assert property ($rose(window_match_flag) |-> $past(conv_done, 2))
    else $error("match flag rose without a conversion");
  a_flag_hold: assert property (window_match_flag && !ctrl_wr |=> window_match_flag)
    else $error("match flag dropped on its own");
  a_flag_clear: assert property (
    ctrl_wr && !reg_wdata[`AWC_CTRL_MATCH_BIT] && !$past(conv_done) |=> !window_match_flag)
    else $error("match flag not cleared by write of zero");
  a_irq_rise: assert property (
    $rose(irq) |-> $past(conv_done, 2) || $past(evt_wr) || $past(evt_wr, 2))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(evt_wr) || $past(evt_wr, 2))
    else $error("interrupt fell without a status or mask write");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !window_match_flag && !irq && reg_rdata == 8'h00)
    else $error("outputs not idle after reset");

  c_match: cover property ($rose(window_match_flag));
  c_irq: cover property ($rose(irq));
  c_read_back: cover property (lim_wr ##1 reg_rd);
endmodule : awc_window_comparator_asserts

bind awc_window_comparator awc_window_comparator_asserts i_awc_window_comparator_asserts (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
  .conv_raw(conv_raw), .window_match_flag(window_match_flag), .irq(irq));

// ### testbench/awc_conv_model.sv
// converter core model: one raw result per end-of-conversion pulse
`timescale 1ns/1ns
`include "awc_params.svh"

module awc_conv_model
  import awc_pkg::*;
(
  input wire logic ref_clk,
  output logic conv_done,
  output logic [`AWC_RAW_W-1:0] conv_raw
);
  initial begin
    conv_done = 1'b0;
    conv_raw = 10'h000;
  end
  // raw lines show the inverse after the pulse so stale data never passes as valid
  task automatic convert(input logic [`AWC_RAW_W-1:0] raw);
    @(posedge ref_clk);
    conv_done <= 1'b1;
    conv_raw <= raw;
    @(posedge ref_clk);
    conv_done <= 1'b0;
    conv_raw <= ~raw;
  endtask : convert
endmodule : awc_conv_model

// ### testbench/tb_awc_window_comparator.sv
// self-checking bench of the adc window comparator
`timescale 1ns/1ns
`include "awc_params.svh"

module tb_awc_window_comparator
  import awc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [`AWC_ADDR_W-1:0] reg_addr = 8'h00;
  logic [`AWC_BYTE_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  awc_byte_t reg_rdata;
  awc_byte_t rdata;
  awc_byte_t ctrl;
  logic conv_done;
  logic [`AWC_RAW_W-1:0] conv_raw;
  logic window_match_flag;
  logic irq;
  logic [60:0] r;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  // {diff, left justify, gt, lt, raw, flag, result word}
  logic [60:0] rows [14] = '{
    {2'h0, 16'h0100, 16'h0200, 10'h1ff, 1'b1, 16'h01ff},
    {2'h0, 16'h0100, 16'h0200, 10'h200, 1'b0, 16'h0200},
    {2'h0, 16'h0100, 16'h0200, 10'h100, 1'b0, 16'h0100},
    {2'h0, 16'h0200, 16'h0100, 10'h0ff, 1'b1, 16'h00ff},
    {2'h0, 16'h0200, 16'h0100, 10'h201, 1'b1, 16'h0201},
    {2'h0, 16'h0200, 16'h0100, 10'h150, 1'b0, 16'h0150},
    {2'h2, 16'hffff, 16'h0100, 10'h000, 1'b1, 16'h0000},
    {2'h2, 16'hffff, 16'h0100, 10'h3ff, 1'b0, 16'hffff},
    {2'h2, 16'h0100, 16'hffff, 10'h3fe, 1'b1, 16'hfffe},
    {2'h1, 16'h4000, 16'h8000, 10'h1ff, 1'b1, 16'h7fc0},
    {2'h1, 16'h4000, 16'h8000, 10'h200, 1'b0, 16'h8000},
    {2'h3, 16'hffc0, 16'h2000, 10'h000, 1'b1, 16'h0000},
    {2'h3, 16'hffc0, 16'h2000, 10'h3ff, 1'b0, 16'hffc0},
    {2'h0, 16'hffff, 16'h0000, 10'h3ff, 1'b0, 16'h03ff}};

  always #5 ref_clk = ~ref_clk;

  awc_window_comparator i_awc_window_comparator (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_done(conv_done), .conv_raw(conv_raw),
    .window_match_flag(window_match_flag), .irq(irq));
  awc_conv_model i_awc_conv_model (.ref_clk(ref_clk), .conv_done(conv_done),
    .conv_raw(conv_raw));

  // ----------------------------------------------------------------------------
  // bus, compare and closing tasks
  // ----------------------------------------------------------------------------
  task automatic wr(input awc_byte_t a, input awc_byte_t d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic chk_byte(input string n, input awc_byte_t e, input awc_byte_t g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_byte(n, {7'h00, e}, {7'h00, g});
  endtask : chk_bit
  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_chk(input string n, input awc_byte_t a, input awc_byte_t e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rdata = reg_rdata;
    chk_byte(n, e, rdata);
  endtask : rd_chk
  // write then read back with no idle cycle between the strobes
  task automatic wr_rd(input string n, input awc_byte_t a, input awc_byte_t d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rdata = reg_rdata;
    chk_byte(n, d, rdata);
  endtask : wr_rd
  task automatic cfg(input awc_byte_t c, input awc_word_t gt, input awc_word_t lt);
    wr(`AWC_OFS_CTRL, c);
    wr(`AWC_OFS_GT_LOW, gt[7:0]);
    wr(`AWC_OFS_GT_HIGH, gt[15:8]);
    wr(`AWC_OFS_LT_LOW, lt[7:0]);
    wr(`AWC_OFS_LT_HIGH, lt[15:8]);
  endtask : cfg
  task automatic conv(input logic [`AWC_RAW_W-1:0] raw);
    i_awc_conv_model.convert(raw);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : conv
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  // the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk("gt_limit_low_byte", `AWC_OFS_GT_LOW, `AWC_RST_GT_LOW);
    rd_chk("gt_limit_high_byte", `AWC_OFS_GT_HIGH, 8'hff);
    rd_chk("lt_limit_low_byte", `AWC_OFS_LT_LOW, 8'h00);
    rd_chk("lt_limit_high_byte", `AWC_OFS_LT_HIGH, `AWC_RST_LT_HIGH);
    rd_chk("unmapped", 8'h00, 8'h00);
    wr_rd("gt_limit_low_byte", `AWC_OFS_GT_LOW, 8'h5a);
    rd_chk("gt_limit_high_byte", `AWC_OFS_GT_HIGH, 8'hff);
    for (int i = 0; i < 14; i++) begin
      r = rows[i];
      ctrl = 8'h00;
      ctrl[`AWC_CTRL_DIFF_BIT] = r[60];
      ctrl[`AWC_CTRL_LJST_BIT] = r[59];
      cfg(ctrl, r[58:43], r[42:27]);
      conv(r[26:17]);
      chk_bit("window_match_flag", r[16], window_match_flag);
      rd_chk("result_high", `AWC_OFS_RES_HIGH, r[15:8]);
      rd_chk("result_low", `AWC_OFS_RES_LOW, r[7:0]);
    end
    // sticky flag, polled and interrupt views
    wr(`AWC_OFS_IRQ_STATUS, 8'h03);
    wr(`AWC_OFS_IRQ_MASK, 8'h01);
    cfg(8'h00, 16'h0100, 16'h0200);
    conv(10'h1ff);
    chk_bit("irq", 1'b1, irq);
    rd_chk("irq_status", `AWC_OFS_IRQ_STATUS, 8'h03);
    conv(10'h300);
    chk_bit("window_match_flag", 1'b1, window_match_flag);
    rd_chk("converter_control_reg", `AWC_OFS_CTRL, 8'h02);
    wr(`AWC_OFS_CTRL, 8'h02);
    wr(`AWC_OFS_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1;
    chk_bit("irq", 1'b0, irq);
    chk_bit("window_match_flag", 1'b1, window_match_flag);
    wr(`AWC_OFS_CTRL, 8'h00);
    #1;
    chk_bit("window_match_flag", 1'b0, window_match_flag);
    wr(`AWC_OFS_IRQ_MASK, 8'h00);
    conv(10'h1ff);
    chk_bit("irq", 1'b0, irq);
    chk_bit("window_match_flag", 1'b1, window_match_flag);
    // a clear write landing in the cycle of a match: the set must win
    wr(`AWC_OFS_CTRL, 8'h00);
    fork
      i_awc_conv_model.convert(10'h1ff);
      begin
        @(posedge ref_clk);
        wr(`AWC_OFS_CTRL, 8'h00);
      end
    join
    #1;
    chk_bit("window_match_flag", 1'b1, window_match_flag);
    wr(`AWC_OFS_IRQ_MASK, 8'h01);
    #1;
    chk_bit("irq", 1'b1, irq);
    // reset in mid-run; held three edges so no stale edge reaches the checks
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    chk_bit("window_match_flag", 1'b0, window_match_flag);
    chk_bit("irq", 1'b0, irq);
    rd_chk("gt_limit_high_byte", `AWC_OFS_GT_HIGH, 8'hff);
    rd_chk("lt_limit_high_byte", `AWC_OFS_LT_HIGH, 8'h00);
    conclude();
  end
endmodule : tb_awc_window_comparator
